// *** common/aux_out_map.vh ***
// register map, field positions, reset values and timing figures of the aux output block
// Behaviour
// - aux A rise waits its startup code times step
// - aux A fall waits shutdown code; zero is immediate
// - aux B rise waits its own startup code
// - aux B fall waits its own shutdown code
// - startup range bit picks 0.5 or 1 ms
// - shutdown range bit picks 0.5 or 1 ms
// - aux A level bit sets output low/high
// - aux A gating bit ANDs level with enable
// - aux B gating bit ANDs level with enable
// - aux B level acts only in output function
// - drive-type bit: 0 push-pull, 1 open-drain (default)
// - shared pin: 0 aux B, 1 clock input
// - enable-pin pull-down bit, connected by default
// - thermal warning threshold 125 or 137 degC
// - spread spectrum bit, on by default
`ifndef AUX_OUT_MAP_VH
`define AUX_OUT_MAP_VH

// ********************************
// register offsets
// ********************************
`define AUX_ADDR_A_DELAYS 8'h10
`define AUX_ADDR_B_DELAYS 8'h11
`define AUX_ADDR_CONTROL 8'h12
`define AUX_ADDR_CONFIG 8'h13

// ********************************
// reset values
// ********************************
`define AUX_RST_A_DELAYS 8'h00
`define AUX_RST_B_DELAYS 8'h00
`define AUX_RST_CONTROL 8'h44
`define AUX_RST_CONFIG 8'h1F

// ********************************
// delay register fields
// ********************************
`define AUX_DLY_RISE_LSB 0
`define AUX_DLY_FALL_LSB 4

// ********************************
// control register fields
// ********************************
`define AUX_CTL_A_LEVEL 0
`define AUX_CTL_A_GATING 1
`define AUX_CTL_A_DRIVE 2
`define AUX_CTL_B_LEVEL 4
`define AUX_CTL_B_GATING 5
`define AUX_CTL_B_DRIVE 6
`define AUX_CTL_WRITE_MASK 8'h77

// ********************************
// configuration register fields
// ********************************
`define AUX_CFG_SPREAD 0
`define AUX_CFG_THERMAL 1
`define AUX_CFG_ENABLE_PIN_PULLDOWN 2
`define AUX_CFG_SHARED_PD 3
`define AUX_CFG_SHARED_FN 4
`define AUX_CFG_FALL_RANGE 5
`define AUX_CFG_RISE_RANGE 6

// ********************************
// timing
// ********************************
`define AUX_CLK_MHZ 100
`define AUX_HALF_STEP_US 500
`define AUX_HALF_STEP_CYCLES (`AUX_HALF_STEP_US * `AUX_CLK_MHZ)

`endif

// *** core/pin_sync.v ***
// two-flop synchroniser for the asynchronous enable pin
`timescale 1ns/1ps

module pin_sync
(
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // pin side
    input wire pin_raw,
    // logic side
    output reg pin_sync_q
);

    reg meta_q;

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= pin_raw;
            pin_sync_q <= meta_q;
        end
    end

endmodule // pin_sync

// *** core/edge_delay_timer.v ***
// one output's delayed copy of the enable level, timed in half steps
`timescale 1ns/1ps

module edge_delay_timer
#(
    parameter HALF_STEP_CYCLES = 50000,
    parameter SUB_W = 16
)
(
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // enable level, already synchronised, and its previous sample
    input wire en_now,
    input wire en_prev,
    // delay codes and ranges
    input wire [3:0] rise_code,
    input wire [3:0] fall_code,
    input wire rise_long,
    input wire fall_long,
    // delayed enable level
    output reg seq_q
);

    reg [4:0] halves_q;
    reg [SUB_W-1:0] sub_q;
    reg target_q;
    reg pend_q;
    wire [3:0] code;
    wire long_range;
    wire [4:0] load_halves;
    wire sub_last;

    assign code = en_now ? rise_code : fall_code;
    assign long_range = en_now ? rise_long : fall_long;
    // long range counts each code step as two half steps
    assign load_halves = long_range ? {code, 1'b0} : {1'b0, code};
    assign sub_last = (sub_q == HALF_STEP_CYCLES[SUB_W-1:0] - {{(SUB_W-1){1'b0}}, 1'b1});

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            halves_q <= 5'h0;
            sub_q <= {SUB_W{1'b0}};
            target_q <= 1'b0;
            pend_q <= 1'b0;
            seq_q <= 1'b0;
        end
        else if (en_now != en_prev)
        begin
            // a fresh edge drops whatever was pending
            target_q <= en_now;
            sub_q <= {SUB_W{1'b0}};
            halves_q <= load_halves;
            if (load_halves == 5'h0)
            begin
                // code zero: follow the pin at once
                seq_q <= en_now;
                pend_q <= 1'b0;
            end
            else
            begin
                pend_q <= 1'b1;
            end
        end
        else if (pend_q)
        begin
            if (sub_last)
            begin
                sub_q <= {SUB_W{1'b0}};
                halves_q <= halves_q - 5'h1;
                if (halves_q == 5'h1)
                begin
                    // delay spent, take the new level
                    seq_q <= target_q;
                    pend_q <= 1'b0;
                end
            end
            else
            begin
                sub_q <= sub_q + {{(SUB_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // edge_delay_timer

// *** core/aux_out_ctrl.v ***
// register file and pin drivers of the two sequenced auxiliary outputs
`timescale 1ns/1ps
`include "aux_out_map.vh"

module aux_out_ctrl
#(
    // cycles in one 0.5 ms step; shorten for simulation
    parameter HALF_STEP_CYCLES = `AUX_HALF_STEP_CYCLES,
    parameter SUB_W = 16
)
(
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // enable pin
    input wire enable_pin,
    // aux output A pin
    output reg aux_out_a_o,
    output reg aux_out_a_oe,
    // shared pin: aux output B or clock input
    output reg aux_out_b_o,
    output reg aux_out_b_oe,
    // static controls to analog and clocking
    output reg shared_pin_is_clock,
    output reg shared_pin_pulldown,
    output reg enable_pin_pulldown,
    output reg thermal_warn_threshold,
    output reg spread_spectrum_on
);

    // ********************************
    // registers
    // ********************************
    reg [7:0] first_output_delays_q;
    reg [7:0] second_output_delays_q;
    reg [7:0] aux_output_control_q;
    reg [7:0] general_configuration_q;
    reg en_prev_q;
    wire en_sync;
    wire seq_a;
    wire seq_b;
    reg [7:0] rdata_d;
    reg a_val_d;
    reg b_val_d;

    // ********************************
    // register writes
    // ********************************
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            first_output_delays_q <= `AUX_RST_A_DELAYS;
            second_output_delays_q <= `AUX_RST_B_DELAYS;
            aux_output_control_q <= `AUX_RST_CONTROL;
            general_configuration_q <= `AUX_RST_CONFIG;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `AUX_ADDR_A_DELAYS:
                begin
                    first_output_delays_q <= reg_wdata;
                end
                `AUX_ADDR_B_DELAYS:
                begin
                    second_output_delays_q <= reg_wdata;
                end
                `AUX_ADDR_CONTROL:
                begin
                    // bits 7 and 3 are read-only zero
                    aux_output_control_q <= reg_wdata & `AUX_CTL_WRITE_MASK;
                end
                `AUX_ADDR_CONFIG:
                begin
                    general_configuration_q <= reg_wdata;
                end
                default:
                begin
                    first_output_delays_q <= first_output_delays_q;
                end
            endcase
        end
    end

    // ********************************
    // register reads
    // ********************************
    always @*
    begin
        case (reg_addr)
            `AUX_ADDR_A_DELAYS: rdata_d = first_output_delays_q;
            `AUX_ADDR_B_DELAYS: rdata_d = second_output_delays_q;
            `AUX_ADDR_CONTROL: rdata_d = aux_output_control_q;
            `AUX_ADDR_CONFIG: rdata_d = general_configuration_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= rdata_d;
        end
    end

    // ********************************
    // enable pin and delay timers
    // ********************************
    pin_sync u_en_sync
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_raw(enable_pin),
        .pin_sync_q(en_sync)
    );

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            en_prev_q <= 1'b0;
        end
        else
        begin
            en_prev_q <= en_sync;
        end
    end

    // one timer per output so each keeps its own codes
    edge_delay_timer
    #(
        .HALF_STEP_CYCLES(HALF_STEP_CYCLES),
        .SUB_W(SUB_W)
    )
    u_timer_a
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .en_now(en_sync),
        .en_prev(en_prev_q),
        .rise_code(first_output_delays_q[`AUX_DLY_RISE_LSB +: 4]),
        .fall_code(first_output_delays_q[`AUX_DLY_FALL_LSB +: 4]),
        .rise_long(general_configuration_q[`AUX_CFG_RISE_RANGE]),
        .fall_long(general_configuration_q[`AUX_CFG_FALL_RANGE]),
        .seq_q(seq_a)
    );

    edge_delay_timer
    #(
        .HALF_STEP_CYCLES(HALF_STEP_CYCLES),
        .SUB_W(SUB_W)
    )
    u_timer_b
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .en_now(en_sync),
        .en_prev(en_prev_q),
        .rise_code(second_output_delays_q[`AUX_DLY_RISE_LSB +: 4]),
        .fall_code(second_output_delays_q[`AUX_DLY_FALL_LSB +: 4]),
        .rise_long(general_configuration_q[`AUX_CFG_RISE_RANGE]),
        .fall_long(general_configuration_q[`AUX_CFG_FALL_RANGE]),
        .seq_q(seq_b)
    );

    // ********************************
    // output levels
    // ********************************
    always @*
    begin
        // level bit alone, or level AND delayed enable
        a_val_d = aux_output_control_q[`AUX_CTL_A_LEVEL] &
            (~aux_output_control_q[`AUX_CTL_A_GATING] | seq_a);
        // same for B
        b_val_d = aux_output_control_q[`AUX_CTL_B_LEVEL] &
            (~aux_output_control_q[`AUX_CTL_B_GATING] | seq_b);
    end

    // ********************************
    // pin drivers
    // ********************************
    // open drain only ever pulls low; a high comes from the external pull-up
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            aux_out_a_o <= 1'b0;
            aux_out_a_oe <= 1'b1;
            aux_out_b_o <= 1'b0;
            aux_out_b_oe <= 1'b0;
        end
        else
        begin
            if (aux_output_control_q[`AUX_CTL_A_DRIVE])
            begin
                aux_out_a_o <= 1'b0;
                aux_out_a_oe <= ~a_val_d;
            end
            else
            begin
                aux_out_a_o <= a_val_d;
                aux_out_a_oe <= 1'b1;
            end
            if (general_configuration_q[`AUX_CFG_SHARED_FN])
            begin
                // pin belongs to the clock input, never drive it
                aux_out_b_o <= 1'b0;
                aux_out_b_oe <= 1'b0;
            end
            else if (aux_output_control_q[`AUX_CTL_B_DRIVE])
            begin
                aux_out_b_o <= 1'b0;
                aux_out_b_oe <= ~b_val_d;
            end
            else
            begin
                aux_out_b_o <= b_val_d;
                aux_out_b_oe <= 1'b1;
            end
        end
    end

    // ********************************
    // static configuration outputs
    // ********************************
    // registered copies so every top output leaves a flop
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            shared_pin_is_clock <= 1'b1;
            shared_pin_pulldown <= 1'b1;
            enable_pin_pulldown <= 1'b1;
            thermal_warn_threshold <= 1'b1;
            spread_spectrum_on <= 1'b1;
        end
        else
        begin
            shared_pin_is_clock <= general_configuration_q[`AUX_CFG_SHARED_FN];
            shared_pin_pulldown <= general_configuration_q[`AUX_CFG_SHARED_PD];
            enable_pin_pulldown <= general_configuration_q[`AUX_CFG_ENABLE_PIN_PULLDOWN];
            thermal_warn_threshold <= general_configuration_q[`AUX_CFG_THERMAL];
            spread_spectrum_on <= general_configuration_q[`AUX_CFG_SPREAD];
        end
    end

endmodule // aux_out_ctrl

// *** verif/aux_out_chk_properties.sv ***
// port-level assertions of the aux output block
`timescale 1ns/1ps

module aux_out_chk
(
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    // pins
    input wire aux_out_a_o,
    input wire aux_out_a_oe,
    input wire aux_out_b_o,
    input wire aux_out_b_oe,
    // static controls
    input wire shared_pin_is_clock,
    input wire shared_pin_pulldown,
    input wire enable_pin_pulldown,
    input wire thermal_warn_threshold,
    input wire spread_spectrum_on
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ****************
    // write steps: the write, then a quiet cycle so the result settles
    // ****************
    sequence s_cfg_wr;
        (reg_wr && reg_addr == 8'h13) ##1 !(reg_wr && reg_addr == 8'h13);
    endsequence
    sequence s_a_wr;
        (reg_wr && reg_addr == 8'h12 && !reg_wdata[1]) ##1 !(reg_wr && reg_addr == 8'h12);
    endsequence
    sequence s_b_wr;
        (reg_wr && reg_addr == 8'h12 && !reg_wdata[5]) ##1 !(reg_wr && reg_addr == 8'h12);
    endsequence

    // ****************
    // properties
    // ****************
    property p_spread;
        s_cfg_wr |=> spread_spectrum_on == $past(reg_wdata[0], 2);
    endproperty
    property p_thermal;
        s_cfg_wr |=> thermal_warn_threshold == $past(reg_wdata[1], 2);
    endproperty
    property p_enable_pin_pulldown;
        s_cfg_wr |=> enable_pin_pulldown == $past(reg_wdata[2], 2);
    endproperty
    property p_sh_pd;
        s_cfg_wr |=> shared_pin_pulldown == $past(reg_wdata[3], 2);
    endproperty
    property p_sh_fn;
        s_cfg_wr |=> shared_pin_is_clock == $past(reg_wdata[4], 2);
    endproperty
    // open drain drives low only; push-pull always drives
    property p_a_ungated;
        s_a_wr |=> aux_out_a_o == ($past(reg_wdata[0], 2) && !$past(reg_wdata[2], 2))
            && aux_out_a_oe == (!$past(reg_wdata[2], 2) || !$past(reg_wdata[0], 2));
    endproperty
    property p_b_ungated;
        s_b_wr |=> shared_pin_is_clock
            || (aux_out_b_o == ($past(reg_wdata[4], 2) && !$past(reg_wdata[6], 2))
            && aux_out_b_oe == (!$past(reg_wdata[6], 2) || !$past(reg_wdata[4], 2)));
    endproperty
    property p_b_clock;
        shared_pin_is_clock && $past(shared_pin_is_clock) |-> !aux_out_b_oe && !aux_out_b_o;
    endproperty
    property p_rst_static;
        $fell(rst) |-> shared_pin_is_clock && shared_pin_pulldown && enable_pin_pulldown
            && thermal_warn_threshold && spread_spectrum_on;
    endproperty

    a_spread: assert property (p_spread) else $error("spread bit mismatch");
    a_thermal: assert property (p_thermal) else $error("thermal bit mismatch");
    a_enable_pin_pulldown: assert property (p_enable_pin_pulldown) else $error("enable pulldown mismatch");
    a_sh_pd: assert property (p_sh_pd) else $error("shared pulldown mismatch");
    a_sh_fn: assert property (p_sh_fn) else $error("shared function mismatch");
    a_a_ungated: assert property (p_a_ungated) else $error("aux a level");
    a_b_ungated: assert property (p_b_ungated) else $error("aux b level");
    a_b_clock: assert property (p_b_clock) else $error("aux b driven as clock");
    a_rst_static: assert property (p_rst_static) else $error("static reset");
endmodule // aux_out_chk

bind aux_out_ctrl aux_out_chk chk_u (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
    .aux_out_a_o, .aux_out_a_oe, .aux_out_b_o, .aux_out_b_oe, .shared_pin_is_clock,
    .shared_pin_pulldown, .enable_pin_pulldown, .thermal_warn_threshold, .spread_spectrum_on);

// *** verif/ext_load.sv ***
// external circuits on the two aux pins, with pull-ups to the analog supply
`timescale 1ns/1ps

module ext_load
(
    // pins
    input wire aux_out_a_o,
    input wire aux_out_a_oe,
    input wire aux_out_b_o,
    input wire aux_out_b_oe,
    // resolved line levels
    output wire line_a,
    output wire line_b
);
    // a released open-drain line is pulled high, never left floating
    assign line_a = aux_out_a_oe ? aux_out_a_o : 1'b1;
    assign line_b = aux_out_b_oe ? aux_out_b_o : 1'b1;
endmodule // ext_load

// *** verif/sequenced_aux_output_ctrl_tb.sv ***
// self-checking bench of the sequenced aux outputs
`timescale 1ns/1ps

module sequenced_aux_output_ctrl_tb;
    // short step keeps the 15-code delays to about 120 cycles
    localparam int H = 4;
    typedef struct packed {logic [3:0] ra; logic [3:0] fa; logic [3:0] rb; logic [3:0] fb;
        logic [7:0] cfg;} row_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic enable_pin = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [15:0] ka, kb;
    wire [7:0] reg_rdata;
    wire a_o, a_oe, b_o, b_oe, line_a, line_b;
    int fail_count = 0;
    int check_count = 0;
    row_t r;
    row_t rows [5] = '{'{0, 0, 1, 2, 8'h0F}, '{15, 1, 3, 0, 8'h45}, '{2, 15, 0, 1, 8'h2A},
        '{1, 1, 1, 1, 8'hE3}, '{15, 15, 15, 15, 8'h60}};
    logic [7:0] rst_exp [5] = '{8'h00, 8'h00, 8'h44, 8'h1F, 8'h00};
    logic [7:0] ctl_val [5] = '{8'h11, 8'h00, 8'h55, 8'h33, 8'h01};
    logic [1:0] ctl_exp [5] = '{2'b11, 2'b00, 2'b11, 2'b00, 2'b10};

    always #5 sys_clk = ~sys_clk;

    aux_out_ctrl #(.HALF_STEP_CYCLES(H)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .enable_pin(enable_pin), .aux_out_a_o(a_o), .aux_out_a_oe(a_oe), .aux_out_b_o(b_o),
        .aux_out_b_oe(b_oe), .shared_pin_is_clock(), .shared_pin_pulldown(),
        .enable_pin_pulldown(), .thermal_warn_threshold(), .spread_spectrum_on());

    ext_load load_u (.aux_out_a_o(a_o), .aux_out_a_oe(a_oe), .aux_out_b_o(b_o),
        .aux_out_b_oe(b_oe), .line_a(line_a), .line_b(line_b));

    // ****************
    // tasks
    // ****************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // edges from the pin change until each line reaches the new level
    task automatic measure(input logic lvl);
        ka = 0;
        kb = 0;
        @(posedge sys_clk);
        #1;
        enable_pin = lvl;
        for (int n = 1; n <= 300 && (ka == 0 || kb == 0); n++)
        begin
            @(posedge sys_clk);
            #1;
            if (ka == 0 && line_a === lvl) ka = 16'(n);
            if (kb == 0 && line_b === lvl) kb = 16'(n);
        end
        if (ka == 0 || kb == 0)
        begin
            fail_count++;
            $display("Error line edge expected %b seen none", lvl);
            wrap_up();
        end
    endtask

    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (6) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 5; i++)
            rd(8'(8'h10 + i), rst_exp[i]);
        wr(8'h12, 8'hFF);
        rd(8'h12, 8'h77);
        wr(8'h14, 8'hFF);
        rd(8'h14, 8'h00);
        wr(8'h13, 8'h0F);
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h12, ctl_val[i]);
            @(posedge sys_clk);
            #1;
            chk("line_a", {15'h0, ctl_exp[i][1]}, {15'h0, line_a});
            chk("line_b", {15'h0, ctl_exp[i][0]}, {15'h0, line_b});
        end
        // both outputs gated by the delayed enable and push-pull, so lines show the timing
        wr(8'h12, 8'h33);
        for (int i = 0; i < 5; i++)
        begin
            r = rows[i];
            wr(8'h13, r.cfg);
            wr(8'h10, {r.fa, r.ra});
            wr(8'h11, {r.fb, r.rb});
            rd(8'h11, {r.fb, r.rb});
            measure(1'b1);
            chk("rise_a", 16'(4 + r.ra * H * (r.cfg[6] ? 2 : 1)), ka);
            chk("rise_b", 16'(4 + r.rb * H * (r.cfg[6] ? 2 : 1)), kb);
            measure(1'b0);
            chk("fall_a", 16'(4 + r.fa * H * (r.cfg[5] ? 2 : 1)), ka);
            chk("fall_b", 16'(4 + r.fb * H * (r.cfg[5] ? 2 : 1)), kb);
        end
        // a fall during a pending rise must cancel it
        wr(8'h10, 8'h0F);
        @(posedge sys_clk);
        #1;
        enable_pin = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        enable_pin = 1'b0;
        ka = 0;
        repeat (140)
        begin
            @(posedge sys_clk);
            #1;
            if (line_a !== 1'b0) ka++;
        end
        chk("retrigger", 16'h0000, ka);
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        rst = 1'b0;
        rd(8'h12, 8'h44);
        wrap_up();
    end
endmodule // sequenced_aux_output_ctrl_tb
